// ### shared/rptc_pkg.sv
// shared constants and types of the rtc power and timebase control block
// assumes a single 20 MHz reference clock and synchronous comparator inputs
package rptc_pkg;

  // clock rate and one-second prescale
  localparam int unsigned REF_CLK_HZ   = 20_000_000;
  localparam int unsigned SEC_PERIOD_S = 1;
  localparam int unsigned SEC_CYCLES   = REF_CLK_HZ * SEC_PERIOD_S;
  localparam int unsigned PRESC_W      = 25;

  // intervals in whole seconds
  localparam int unsigned CNT_W            = 4;
  localparam logic [CNT_W-1:0] PRI_INTERVAL_S  = 4'h1;
  localparam logic [CNT_W-1:0] BAT_INTERVAL_S  = 4'hA;
  localparam logic [CNT_W-1:0] STARTUP_DELAY_S = 4'h2;
  localparam logic [CNT_W-1:0] SEC_LAST        = 4'h1;
  localparam logic [CNT_W-1:0] SEC_STEP        = 4'h1;

  // correction arithmetic widths
  localparam int unsigned OFS_W  = 8;
  localparam int unsigned CORR_W = 9;

  // calendar preset, bcd bytes: year month date weekday hours minutes seconds
  localparam int unsigned CAL_W = 56;
  localparam logic [7:0] CAL_INIT_YEAR  = 8'h00;
  localparam logic [7:0] CAL_INIT_MONTH = 8'h01;
  localparam logic [7:0] CAL_INIT_DATE  = 8'h01;
  localparam logic [7:0] CAL_INIT_DOW   = 8'h01;
  localparam logic [7:0] CAL_INIT_HOUR  = 8'h00;
  localparam logic [7:0] CAL_INIT_MIN   = 8'h00;
  localparam logic [7:0] CAL_INIT_SEC   = 8'h00;
  localparam logic [CAL_W-1:0] CAL_INIT_WORD = {CAL_INIT_YEAR, CAL_INIT_MONTH, CAL_INIT_DATE,
                                                CAL_INIT_DOW, CAL_INIT_HOUR, CAL_INIT_MIN,
                                                CAL_INIT_SEC};

  // temperature correction sequencer
  typedef enum logic [1:0] {
    RPTC_IDLE,
    RPTC_CONV,
    RPTC_APPLY
  } rptc_tb_state_t;

endpackage : rptc_pkg

// ### rtl/rptc_sec_prescaler.sv
// one-second tick generator for the compensated time base
// assumes restart_i is a pulse from the controller; ticks only while run_i is high
module rptc_sec_prescaler
  import rptc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // control
  input  wire logic run_i,
  input  wire logic restart_i,
  // tick
  output logic      sec_tick_o
);

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic               tick;
  } rptc_presc_t;

  localparam logic [PRESC_W-1:0] CNT_LAST = PRESC_W'(SEC_CYCLES_P - 1);
  localparam logic [PRESC_W-1:0] CNT_ONE  = PRESC_W'(1);

  rptc_presc_t st_r;
  rptc_presc_t st_nxt;

  // a stopped oscillator holds the phase at zero so a restart gives a full second
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i || restart_i) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CNT_LAST) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sec_tick_o = st_r.tick;

endmodule : rptc_sec_prescaler

// ### rtl/rptc_corr_adder.sv
// signed sum of the factory trim and the software aging offset
// assumes both operands are stable in the cycle that load_i is high
module rptc_corr_adder
  import rptc_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // operands
  input  wire logic              load_i,
  input  wire logic [OFS_W-1:0]  factory_trim_i,
  input  wire logic [OFS_W-1:0]  aging_offset_i,
  // result
  output logic      [CORR_W-1:0] correction_o
);

  typedef struct packed {
    logic [CORR_W-1:0] corr;
  } rptc_corr_t;

  rptc_corr_t st_r;
  rptc_corr_t st_nxt;

  // one extra bit so the sum of two extremes never wraps
  always_comb begin
    st_nxt = st_r;
    if (load_i) begin
      st_nxt.corr = CORR_W'($signed(factory_trim_i)) + CORR_W'($signed(aging_offset_i));
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign correction_o = st_r.corr;

endmodule : rptc_corr_adder

// ### rtl/rptc_power_timebase.sv
// power-source selection, reset pin drive and compensated time base control
// assumes comparator results arrive synchronous to ref_clk_i and already filtered;
// the temperature sensor answers a conversion request with a one-cycle done pulse
// and presents the factory trim for that reading in the same cycle

module rptc_power_timebase
  import rptc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // supply comparators
  input  wire logic              vcc_present_i,
  input  wire logic              vcc_above_pf_i,
  input  wire logic              vcc_above_bat_i,
  // host side events and settings
  input  wire logic              i2c_addr_wr_i,
  input  wire logic              oscillator_enable_n_i,
  input  wire logic [OFS_W-1:0]  aging_offset_i,
  // temperature sensor
  input  wire logic              temp_done_i,
  input  wire logic [OFS_W-1:0]  factory_trim_i,
  output logic                   conv_start_o,
  // supply selection and reset pin
  output logic                   backup_sel_o,
  output logic                   rst_n_o,
  output logic                   rst_oe_o,
  // oscillator
  output logic                   osc_run_o,
  output logic                   retain_only_o,
  // time base correction
  output logic                   adjust_o,
  output logic      [CORR_W-1:0] correction_o,
  // calendar preset
  output logic                   cal_load_o,
  output logic      [CAL_W-1:0]  cal_value_o
);

  typedef struct packed {
    logic             backup_sel;
    logic             pf_ok;
    logic             pri_seen;
    logic             i2c_seen;
    logic             osc_started;
    logic             osc_run;
    logic             retain;
    logic             rst_n;
    logic             rst_oe;
    rptc_tb_state_t   state;
    logic [CNT_W-1:0] sec_left;
    logic             conv_start;
    logic             adjust;
    logic             cal_load;
    logic [CAL_W-1:0] cal_value;
  } rptc_ctl_t;

  rptc_ctl_t st_r;
  rptc_ctl_t st_nxt;

  logic sec_tick;
  logic restart;
  logic backup_now;
  logic arrival;
  logic wr_start;
  logic src_change;
  logic adj_take;

  // period between corrections for the selected source
  function automatic logic [CNT_W-1:0] interval_for(input logic on_backup);
    logic [CNT_W-1:0] ival;
    ival = on_backup ? BAT_INTERVAL_S : PRI_INTERVAL_S;
    return ival;
  endfunction : interval_for

  // source decision straight from the comparators
  always_comb begin
    backup_now = !vcc_above_pf_i && !vcc_above_bat_i;
    arrival    = vcc_above_pf_i && !st_r.pf_ok;
    wr_start   = i2c_addr_wr_i && !st_r.osc_started;
    src_change = backup_now != st_r.backup_sel;
    restart    = arrival || wr_start || src_change;
    // trim is only valid in the done cycle, so the adder loads right then
    adj_take   = (st_r.state == RPTC_CONV) && temp_done_i;
  end

  // controller next state
  always_comb begin
    st_nxt            = st_r;
    st_nxt.conv_start = 1'b0;
    st_nxt.adjust     = 1'b0;
    st_nxt.cal_load   = 1'b0;
    st_nxt.pf_ok      = vcc_above_pf_i;
    st_nxt.backup_sel = backup_now;

    // reset pin: open-drain pull low below threshold, undriven without primary
    st_nxt.rst_oe = vcc_present_i && !vcc_above_pf_i;
    st_nxt.rst_n  = vcc_above_pf_i;

    // the started flag is never cleared, only power loss resets it
    if (vcc_above_pf_i || i2c_addr_wr_i) begin
      st_nxt.osc_started = 1'b1;
    end
    st_nxt.retain  = backup_now && oscillator_enable_n_i;
    st_nxt.osc_run = st_nxt.osc_started && !st_nxt.retain;

    // calendar preset, once per trigger kind
    if (vcc_above_pf_i && !st_r.pri_seen) begin
      st_nxt.pri_seen  = 1'b1;
      st_nxt.cal_load  = 1'b1;
      st_nxt.cal_value = CAL_INIT_WORD;
    end else if (backup_now && i2c_addr_wr_i && !st_r.i2c_seen) begin
      st_nxt.i2c_seen  = 1'b1;
      st_nxt.cal_load  = 1'b1;
      st_nxt.cal_value = CAL_INIT_WORD;
    end

    // second countdown; a startup delay outranks a plain source change
    if (arrival || wr_start) begin
      st_nxt.sec_left = STARTUP_DELAY_S;
    end else if (src_change) begin
      st_nxt.sec_left = interval_for(backup_now);
    end else if (sec_tick) begin
      if (st_r.sec_left == SEC_LAST || st_r.sec_left == '0) begin
        st_nxt.sec_left = interval_for(st_r.backup_sel);
      end else begin
        st_nxt.sec_left = st_r.sec_left - SEC_STEP;
      end
    end

    // conversion and correction sequence; a due tick while busy is skipped
    unique case (st_r.state)
      RPTC_IDLE: begin
        if (sec_tick && !restart && st_r.sec_left == SEC_LAST) begin
          st_nxt.conv_start = 1'b1;
          st_nxt.state      = RPTC_CONV;
        end
      end
      RPTC_CONV: begin
        if (temp_done_i) begin
          st_nxt.state    = RPTC_APPLY;
        end
      end
      RPTC_APPLY: begin
        st_nxt.adjust = 1'b1;
        st_nxt.state  = RPTC_IDLE;
      end
    endcase

    // stopping the oscillator abandons a conversion in flight
    if (!st_nxt.osc_run && st_r.state == RPTC_CONV) begin
      st_nxt.state = RPTC_IDLE;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one-second tick only while the oscillator runs
  rptc_sec_prescaler #(
    .SEC_CYCLES_P (SEC_CYCLES_P)
  ) u_presc (
    .ref_clk_i    (ref_clk_i),
    .arst_n_i     (arst_n_i),
    .run_i        (st_r.osc_run),
    .restart_i    (restart),
    .sec_tick_o   (sec_tick)
  );

  // registered correction value, valid with adjust_o
  rptc_corr_adder u_corr (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .load_i         (adj_take),
    .factory_trim_i (factory_trim_i),
    .aging_offset_i (aging_offset_i),
    .correction_o   (correction_o)
  );

  // outputs come straight from the state register
  assign conv_start_o  = st_r.conv_start;
  assign backup_sel_o  = st_r.backup_sel;
  assign rst_n_o       = st_r.rst_n;
  assign rst_oe_o      = st_r.rst_oe;
  assign osc_run_o     = st_r.osc_run;
  assign retain_only_o = st_r.retain;
  assign adjust_o      = st_r.adjust;
  assign cal_load_o    = st_r.cal_load;
  assign cal_value_o   = st_r.cal_value;

endmodule : rptc_power_timebase

// ### bench/rptc_sensor_model.sv
// temperature sensor stand-in answering each request after dly_i cycles
// assumes one-cycle requests; trim is only meaningful in the done cycle
module rptc_sensor_model (
  input  wire logic       ref_clk_i, start_i,
  input  wire logic [3:0] dly_i,
  input  wire logic [7:0] trim_i,
  output logic            done_o = 1'b0,
  output logic      [7:0] trim_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // count down then pulse done; trim toggles otherwise so stale data never matches
  always @(negedge ref_clk_i) begin
    done_o <= 1'b0;
    trim_o <= ~trim_o;
    if (start_i === 1'b1) cnt = dly_i;
    else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        done_o <= 1'b1;
        trim_o <= trim_i;
      end
    end
  end
endmodule : rptc_sensor_model

// ### bench/rptc_power_timebase_sva.sv
// assertions on the ports of the power and timebase control block
// assumes SEC_CYCLES_P matches the bound instance
module rptc_power_timebase_sva
  import rptc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
  // clock, reset and inputs
  input wire logic ref_clk_i, arst_n_i, vcc_present_i, vcc_above_pf_i,
  input wire logic vcc_above_bat_i, i2c_addr_wr_i, oscillator_enable_n_i, temp_done_i,
  input wire logic [OFS_W-1:0] aging_offset_i, factory_trim_i,
  // outputs
  input wire logic conv_start_o, backup_sel_o, rst_n_o, rst_oe_o, osc_run_o,
  input wire logic retain_only_o, adjust_o, cal_load_o,
  input wire logic [CORR_W-1:0] correction_o,
  input wire logic [CAL_W-1:0] cal_value_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [31:0] gap_r;
  logic steady_r;
  wire logic [CORR_W-1:0] sum_w = {factory_trim_i[OFS_W-1], factory_trim_i}
                                  + {aging_offset_i[OFS_W-1], aging_offset_i};
  // cycles since last request; steady only while source and oscillator stay put
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_r <= 32'h0;
      steady_r <= 1'b0;
    end else begin
      gap_r <= conv_start_o ? 32'h1 : gap_r + 32'h1;
      steady_r <= (conv_start_o | steady_r) & osc_run_o & $stable(backup_sel_o)
                  & $stable(vcc_above_pf_i);
    end
  end
  sequence s_bat_stop;
    (!vcc_above_pf_i && !vcc_above_bat_i && oscillator_enable_n_i) [*3];
  endsequence
  property p_pri_sel; vcc_above_pf_i |=> !backup_sel_o; endproperty
  a_pri_sel: assert property (p_pri_sel) else $error("primary dropped");
  property p_bat_sel; !vcc_above_pf_i && !vcc_above_bat_i |=> backup_sel_o; endproperty
  a_bat_sel: assert property (p_bat_sel) else $error("backup not taken");
  property p_rst_act; vcc_present_i && !vcc_above_pf_i |=> !rst_n_o && rst_oe_o; endproperty
  a_rst_act: assert property (p_rst_act) else $error("reset not driven");
  property p_rst_off; !vcc_present_i |=> !rst_oe_o; endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset driven");
  property p_retain; s_bat_stop |=> retain_only_o && !osc_run_o; endproperty
  a_retain: assert property (p_retain) else $error("no retain mode");
  property p_start; i2c_addr_wr_i && !oscillator_enable_n_i |=> osc_run_o; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_run; $fell(osc_run_o) |-> ##[0:1] retain_only_o; endproperty
  a_run: assert property (p_run) else $error("oscillator stopped");
  property p_adj;
    adjust_o |-> $past(temp_done_i, 2) && correction_o == $past(sum_w, 2);
  endproperty
  a_adj: assert property (p_adj) else $error("bad correction");
  property p_pri_per; conv_start_o && steady_r && !backup_sel_o |-> gap_r == SEC_CYCLES_P;
  endproperty
  a_pri_per: assert property (p_pri_per) else $error("bad 1 s gap");
  property p_bat_per; conv_start_o && steady_r && backup_sel_o |-> gap_r == 10 * SEC_CYCLES_P;
  endproperty
  a_bat_per: assert property (p_bat_per) else $error("bad 10 s gap");
  property p_cal; cal_load_o |-> cal_value_o == CAL_INIT_WORD; endproperty
  a_cal: assert property (p_cal) else $error("bad preset");
endmodule : rptc_power_timebase_sva

bind rptc_power_timebase rptc_power_timebase_sva #(.SEC_CYCLES_P(SEC_CYCLES_P))
  rptc_power_timebase_sva_i (.*);

// ### bench/rptc_power_timebase_tb.sv
// self-checking bench for the power and timebase control, shortened second
// assumes the sensor model answers well inside one second
module rptc_power_timebase_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rptc_pkg::*;
  localparam int unsigned SEC_P = 20;
  logic ref_clk_i = 0, arst_n_i = 0, vcc_present_i = 0, vcc_above_pf_i = 0;
  logic vcc_above_bat_i = 0, i2c_addr_wr_i = 0, oscillator_enable_n_i = 0;
  logic temp_done_i, conv_start_o, backup_sel_o, rst_n_o, rst_oe_o, osc_run_o;
  logic retain_only_o, adjust_o, cal_load_o, p_pf, p_bat, p_pr, p_rs = 0;
  logic [OFS_W-1:0] aging_offset_i = 8'h80, factory_trim_i, s_trim = 8'h80;
  logic [3:0] s_dly = 4'h3;
  logic [CORR_W-1:0] correction_o, exp_q[$];
  logic [CAL_W-1:0] cal_value_o;
  int errors = 0, n_checks = 0, n_cal = 0, n_conv = 0, n, sa, sb;

  rptc_power_timebase #(.SEC_CYCLES_P(SEC_P)) rptc_power_timebase_i (.*);
  rptc_sensor_model rptc_sensor_model_i (.ref_clk_i, .start_i(conv_start_o), .dly_i(s_dly),
    .trim_i(s_trim), .done_o(temp_done_i), .trim_o(factory_trim_i));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // counts falling edges until the next conversion request
  task automatic wait_conv(input int lo, input int hi);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (conv_start_o !== 1'b1 && k < hi + 4);
    chk(k >= lo && k <= hi, 1);
  endtask : wait_conv

  // sample inputs at the edge; queue the correction each done should bring
  always @(posedge ref_clk_i) begin
    {p_pf, p_bat, p_pr, p_rs} = {vcc_above_pf_i, vcc_above_bat_i, vcc_present_i, arst_n_i};
    sa = $signed(factory_trim_i);
    sb = $signed(aging_offset_i);
    if (temp_done_i === 1'b1) exp_q.push_back(CORR_W'(sa + sb));
  end

  // compare settled outputs with the model every cycle
  always @(negedge ref_clk_i) if (p_rs) begin
    chk(backup_sel_o, !p_pf && !p_bat);
    chk({rst_n_o, rst_oe_o}, {p_pf, p_pr && !p_pf});
    if (adjust_o === 1'b1) chk(correction_o, exp_q.pop_front());
    if (cal_load_o === 1'b1) n_cal++;
    if (cal_load_o === 1'b1) chk(cal_value_o, 56'h00010101000000);
    if (conv_start_o === 1'b1) n_conv++;
  end

  // main sequence
  initial begin
    n = $urandom(70);
    repeat (16) @(negedge ref_clk_i);
    arst_n_i = 1;
    repeat (5 * SEC_P) @(negedge ref_clk_i);
    chk({osc_run_o, n_conv[3:0]}, 0);
    i2c_addr_wr_i = 1;
    @(negedge ref_clk_i) i2c_addr_wr_i = 0;
    @(negedge ref_clk_i);
    chk({osc_run_o, n_cal[3:0]}, 5'h11);
    wait_conv(2 * SEC_P - 3, 2 * SEC_P + 2);
    wait_conv(10 * SEC_P, 10 * SEC_P);
    $display("test 1 done");
    {vcc_present_i, vcc_above_pf_i, vcc_above_bat_i} = 3'h7;
    wait_conv(2 * SEC_P - 3, 2 * SEC_P + 2);
    repeat (4) begin
      {aging_offset_i, s_trim} = 16'($urandom);
      s_dly = 4'(1 + $urandom % 8);
      wait_conv(SEC_P, SEC_P);
    end
    chk(n_cal, 2);
    $display("test 2 done");
    vcc_above_pf_i = 0;
    wait_conv(SEC_P, SEC_P);
    vcc_above_bat_i = 0;
    wait_conv(10 * SEC_P - 2, 10 * SEC_P + 2);
    $display("test 3 done");
    repeat (12) @(negedge ref_clk_i);
    oscillator_enable_n_i = 1;
    n = n_conv;
    repeat (11 * SEC_P) @(negedge ref_clk_i);
    chk({retain_only_o, osc_run_o, n_conv}, {2'b10, n});
    oscillator_enable_n_i = 0;
    repeat (3) @(negedge ref_clk_i);
    chk(osc_run_o, 1);
    $display("test 4 done");
    repeat (300) begin
      @(negedge ref_clk_i);
      if ($urandom % 8 == 0) {vcc_above_pf_i, vcc_above_bat_i} = 2'($urandom);
      vcc_present_i = vcc_above_pf_i | vcc_above_bat_i | 1'($urandom);
    end
    chk(n_cal, 2);
    $display("test 5 done");
    test_done();
  end

  // watchdog, far beyond the roughly 60 shortened seconds the tests need
  initial begin
    #(50 * 200 * SEC_P);
    errors++;
    test_done();
  end
endmodule : rptc_power_timebase_tb
